// ---- hdl/pavt_core.sv ----
/*
 * program memory address generation: reset and interrupt vectors, banked
 * fetch address with deferred bank switch, two-cycle table reads, and an
 * axi4-lite register slave.
 * assumes the core sequencer runs on clk, one clock per instruction cycle,
 * and that the rom array answers rom_data combinationally from rom_addr.
 */
// Register access over AXI4-Lite was left to the implementer.
// Function
// - reset forces fetch address to word 000
// - enabled falling edge external interrupt vectors to 004
// - timer 0 overflow vectors to 008
// - timer 1 overflow vectors to 00c
// - timer 2 overflow vectors to 010
// - rc converter interrupt vectors to 014
// - adpcm interrupt vectors to 018
// - fetch address is bank plus counter
// - banks of 8192 sixteen-bit words
// - bank write takes effect after branch/interrupt
// - bank select decodes only its low bits
// - table address from three pointer registers
// - current mode uses high, middle, low pointers
// - last page mode uses bank, ones, low
// - table address width follows the variant
// - low byte to destination, high byte stored
// - unbacked high byte bits are don't care
// - table high byte is read only
// - table read takes two cycles, rom second
// - full stack holds request, withholds vector
`include "pavt_cfg.svh"
`default_nettype none
module pavt_core (
    input  wire logic        clk,                    // 20 mhz core clock
    input  wire logic        rstn,                   // async reset, active low
    input  wire logic [11:0] s_axi_awaddr,           // write address
    input  wire logic        s_axi_awvalid,          // write address valid
    output logic             s_axi_awready,          // write address ready
    input  wire logic [31:0] s_axi_wdata,            // write data
    input  wire logic [3:0]  s_axi_wstrb,            // write byte enables
    input  wire logic        s_axi_wvalid,           // write data valid
    output logic             s_axi_wready,           // write data ready
    output logic [1:0]       s_axi_bresp,            // write response
    output logic             s_axi_bvalid,           // write response valid
    input  wire logic        s_axi_bready,           // write response ready
    input  wire logic [11:0] s_axi_araddr,           // read address
    input  wire logic        s_axi_arvalid,          // read address valid
    output logic             s_axi_arready,          // read address ready
    output logic [31:0]      s_axi_rdata,            // read data
    output logic [1:0]       s_axi_rresp,            // read response
    output logic             s_axi_rvalid,           // read data valid
    input  wire logic        s_axi_rready,           // read data ready
    input  wire logic [12:0] pc_next,                // in-bank word of next fetch
    input  wire logic        branch_done,            // jump or call completes
    input  wire logic        ext_int_n,              // external interrupt pin
    input  wire logic        tmr0_ovf,               // timer 0 overflow pulse
    input  wire logic        tmr1_ovf,               // timer 1 overflow pulse
    input  wire logic        tmr2_ovf,               // timer 2 overflow pulse
    input  wire logic        rc_converter_interrupt, // rc converter event pulse
    input  wire logic        adpcm_int,              // adpcm event pulse
    input  wire logic [4:0]  int_enable,             // ext, t0, t1, t2, adpcm
    input  wire logic        stack_full,             // no free stack level
    input  wire logic        tbl_start,              // table read request
    input  wire logic        tbl_last_page,          // 1: last page mode
    input  wire logic [7:0]  tbl_dest,               // destination register
    input  wire logic [15:0] rom_data,               // rom word
    output logic [17:0]      rom_addr,               // rom word address
    output logic             rom_sel_tbl,            // rom used by table read
    output logic [17:0]      fetch_addr,             // instruction fetch address
    output logic             vector_take,            // interrupt entry pulse
    output logic             tbl_busy,               // table read under way
    output logic             tbl_done,               // table read result pulse
    output logic [7:0]       tbl_low_data,           // low byte for destination
    output logic [7:0]       tbl_dest_out            // destination register
);
    // software registers
    logic [7:0]  rom_bank_select;      // pending bank, written by software
    logic [7:0]  table_pointer_low;    // table address bits 7..0
    logic [7:0]  table_pointer_middle; // table address bits 15..8
    logic [7:0]  table_pointer_high;   // table address bits 17..16
    logic [7:0]  table_high_byte;      // high byte of last table read
    // bank and interrupt state
    logic [`PAVT_BANK_BITS-1:0] active_bank;  // bank that fetch uses
    logic [`PAVT_NUM_INT-1:0]   pend;         // latched interrupt requests
    logic                       ext_s1;       // pin sync stage 1
    logic                       ext_s2;       // pin sync stage 2
    logic                       ext_s3;       // delayed for edge detect
    // table read state
    pavt_pkg::pavt_tbl_state_t  tbl_state;    // sequence state
    logic [`PAVT_ADDR_BITS-1:0] tbl_addr;     // latched table address
    // axi state
    logic        aw_have;                     // write address held
    logic        w_have;                      // write data held
    logic [11:0] aw_addr;                     // held write address
    logic [31:0] w_data;                      // held write data
    logic [3:0]  w_strb;                      // held byte enables

    // axi channel handshakes; one write and one read in flight at most
    assign s_axi_awready = !aw_have && !s_axi_bvalid;
    assign s_axi_wready  = !w_have && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    wire       aw_hs   = s_axi_awvalid && s_axi_awready;
    wire       w_hs    = s_axi_wvalid && s_axi_wready;
    wire       ar_hs   = s_axi_arvalid && s_axi_arready;
    wire [11:0] wa     = aw_hs ? s_axi_awaddr : aw_addr;
    wire [31:0] wd     = w_hs ? s_axi_wdata : w_data;
    wire [3:0]  ws     = w_hs ? s_axi_wstrb : w_strb;
    wire       wr_go   = (aw_have || aw_hs) && (w_have || w_hs);
    wire [7:0] widx    = wa[9:2];
    wire [7:0] ridx    = s_axi_araddr[9:2];
    wire       wr_lo   = wr_go && ws[0];
    // only word offsets below the index range decode; upper address bits
    // must be zero so aliases answer as unmapped
    wire       wr_ok   = (wa[11:10] == 2'b00) && (wa[1:0] == 2'b00);
    wire       rd_ok   = (s_axi_araddr[11:10] == 2'b00) && (s_axi_araddr[1:0] == 2'b00);
    wire       w_bank  = wr_lo && wr_ok && widx == `PAVT_IDX_BANK;
    wire       w_tlow  = wr_lo && wr_ok && widx == `PAVT_IDX_TBL_LOW;
    wire       w_tmid  = wr_lo && wr_ok && widx == `PAVT_IDX_TBL_MID;
    wire       w_thigh = wr_lo && wr_ok && widx == `PAVT_IDX_TBL_HIGH;
    // writes to table_high_byte and status are accepted with okay and dropped
    wire       w_known = wr_ok && (widx == `PAVT_IDX_BANK || widx == `PAVT_IDX_TBL_LOW
                         || widx == `PAVT_IDX_TBL_MID || widx == `PAVT_IDX_TBL_HIGH
                         || widx == `PAVT_IDX_TBL_HB || widx == `PAVT_IDX_STATUS);

    // status word: pending requests, active bank, table busy
    wire [31:0] stat_word = {26'h0, pend}
                          | (32'(active_bank) << `PAVT_ST_BANK)
                          | (32'(tbl_busy) << `PAVT_ST_BUSY);

    // read decode, unmapped reads return zero with slverr
    logic [31:0] rd_word;
    logic        rd_known;
    always_comb begin
        rd_word  = 32'h0;
        rd_known = rd_ok;
        unique case (ridx)
            `PAVT_IDX_BANK:     rd_word = {24'h0, rom_bank_select};
            `PAVT_IDX_TBL_LOW:  rd_word = {24'h0, table_pointer_low};
            `PAVT_IDX_TBL_MID:  rd_word = {24'h0, table_pointer_middle};
            `PAVT_IDX_TBL_HIGH: rd_word = {24'h0, table_pointer_high};
            `PAVT_IDX_TBL_HB:   rd_word = {24'h0, table_high_byte};
            `PAVT_IDX_STATUS:   rd_word = stat_word;
            default:            rd_known = 1'b0;
        endcase
    end

    // axi write path: hold whichever half arrives first
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            aw_addr      <= 12'h0;
            w_data       <= 32'h0;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PAVT_RESP_OKAY;
        end else begin
            if (aw_hs) aw_addr <= s_axi_awaddr;
            if (w_hs) w_data <= s_axi_wdata;
            if (w_hs) w_strb <= s_axi_wstrb;
            aw_have <= wr_go ? 1'b0 : (aw_have || aw_hs);
            w_have  <= wr_go ? 1'b0 : (w_have || w_hs);
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= w_known ? `PAVT_RESP_OKAY : `PAVT_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read path, answer one cycle after the address is taken
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `PAVT_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_known ? rd_word : 32'h0;
            s_axi_rresp  <= rd_known ? `PAVT_RESP_OKAY : `PAVT_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // software registers; the table pointers feed the table address and the axi read data
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rom_bank_select      <= `PAVT_RST_BANK;
            table_pointer_low    <= `PAVT_RST_TBL;
            table_pointer_middle <= `PAVT_RST_TBL;
            table_pointer_high   <= `PAVT_RST_TBL;
        end else begin
            if (w_bank) rom_bank_select <= wd[7:0];
            if (w_tlow) table_pointer_low <= wd[7:0];
            if (w_tmid) table_pointer_middle <= wd[7:0];
            if (w_thigh) table_pointer_high <= wd[7:0];
        end
    end

    // external pin: two flops, then a third for the falling edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ext_s1 <= 1'b1;
            ext_s2 <= 1'b1;
            ext_s3 <= 1'b1;
        end else begin
            ext_s1 <= ext_int_n;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    // request sources in vector order; rc converter has no enable here
    wire [`PAVT_NUM_INT-1:0] set_req = {adpcm_int, rc_converter_interrupt, tmr2_ovf,
                                        tmr1_ovf, tmr0_ovf, ext_s3 && !ext_s2};
    wire [`PAVT_NUM_INT-1:0] en_req  = {int_enable[4], 1'b1, int_enable[3:0]};
    wire [`PAVT_NUM_INT-1:0] ready   = pend & en_req;
    // a full stack withholds entry but leaves the request latched
    wire take_w = (|ready) && !stack_full && !tbl_busy;

    // lowest vector first among enabled pending requests
    logic [`PAVT_NUM_INT-1:0] pick;
    always_comb begin
        pick = '0;
        for (int i = `PAVT_NUM_INT - 1; i >= 0; i--) begin
            if (ready[i]) pick = `PAVT_NUM_INT'(1) << i;
        end
    end

    // vector word of the chosen source
    logic [`PAVT_ADDR_BITS-1:0] vec;
    always_comb begin
        unique case (1'b1)
            pick[0]: vec = `PAVT_VEC_EXT;
            pick[1]: vec = `PAVT_VEC_T0;
            pick[2]: vec = `PAVT_VEC_T1;
            pick[3]: vec = `PAVT_VEC_T2;
            pick[4]: vec = `PAVT_VEC_RC;
            pick[5]: vec = `PAVT_VEC_ADPCM;
            default: vec = `PAVT_VEC_RESET;
        endcase
    end

    // set wins over the clear of the serviced request
    wire [`PAVT_NUM_INT-1:0] clr = take_w ? pick : '0;
    wire [`PAVT_NUM_INT-1:0] next_pend = (pend & ~clr) | set_req;

    // only the low bank bits decode; the bank applies after entry or branch
    wire [`PAVT_BANK_BITS-1:0] sel_bank = rom_bank_select[`PAVT_BANK_BITS-1:0];
    wire bank_upd = branch_done || take_w;
    wire [`PAVT_BANK_BITS-1:0] next_bank = bank_upd ? sel_bank : active_bank;
    // bank times 8192 words plus in-bank word
    wire [`PAVT_ADDR_BITS-1:0] next_fetch = take_w ? vec
                                          : {next_bank, pc_next};

    // fetch address, bank and interrupt requests
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fetch_addr  <= `PAVT_VEC_RESET;
            active_bank <= '0;
            pend        <= '0;
            vector_take <= 1'b0;
        end else begin
            fetch_addr  <= next_fetch;
            active_bank <= next_bank;
            pend        <= next_pend;
            vector_take <= take_w;
        end
    end

    // table address: current pointers, or last page of the selected bank;
    // bits above the implemented width are dropped
    wire [17:0] cur_full  = {table_pointer_high[1:0], table_pointer_middle,
                             table_pointer_low};
    wire [17:0] last_full = {sel_bank, `PAVT_LAST_PAGE, table_pointer_low};
    wire [`PAVT_ADDR_BITS-1:0] next_tbl_addr = tbl_last_page
                               ? last_full[`PAVT_ADDR_BITS-1:0]
                               : cur_full[`PAVT_ADDR_BITS-1:0];
    wire tbl_go = tbl_start && (tbl_state == pavt_pkg::PAVT_TBL_IDLE);

    // table read sequence: address cycle, then rom cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tbl_state <= pavt_pkg::PAVT_TBL_IDLE;
        end else begin
            unique case (tbl_state)
                pavt_pkg::PAVT_TBL_IDLE: if (tbl_go) tbl_state <= pavt_pkg::PAVT_TBL_ADDR;
                pavt_pkg::PAVT_TBL_ADDR: tbl_state <= pavt_pkg::PAVT_TBL_DATA;
                pavt_pkg::PAVT_TBL_DATA: tbl_state <= pavt_pkg::PAVT_TBL_IDLE;
                default:                 tbl_state <= pavt_pkg::PAVT_TBL_IDLE;
            endcase
        end
    end

    // table data: low byte with destination out, high byte kept here;
    // unbacked high bits simply carry whatever the rom word holds
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tbl_addr        <= '0;
            tbl_dest_out    <= 8'h0;
            tbl_low_data    <= 8'h0;
            table_high_byte <= 8'h0;
            tbl_done        <= 1'b0;
        end else begin
            if (tbl_go) tbl_addr <= next_tbl_addr;
            if (tbl_go) tbl_dest_out <= tbl_dest;
            if (rom_sel_tbl) tbl_low_data <= rom_data[7:0];
            if (rom_sel_tbl) table_high_byte <= rom_data[15:8];
            tbl_done <= rom_sel_tbl;
        end
    end

    // rom port: table owns it during its second cycle, fetch otherwise
    assign tbl_busy    = tbl_state != pavt_pkg::PAVT_TBL_IDLE;
    assign rom_sel_tbl = tbl_state == pavt_pkg::PAVT_TBL_DATA;
    assign rom_addr    = rom_sel_tbl ? tbl_addr : fetch_addr;

    // checks; table address checks look back to the pointers and bank seen at
    // the start edge, so a pointer write during the read cannot hide a fault

    AST_RESET_FETCH: assert property (@(posedge clk) disable iff (!rstn)
        !$past(rstn) |-> fetch_addr == `PAVT_VEC_RESET)
        else $error("fetch address not zero after reset");
    AST_FETCH_BANK: assert property (@(posedge clk) disable iff (!rstn)
        (!take_w && !branch_done) |=> fetch_addr == {$past(active_bank), $past(pc_next)})
        else $error("fetch address not bank plus counter");
    AST_VEC_EXT: assert property (@(posedge clk) disable iff (!rstn)
        (take_w && ready[0]) |=> vector_take && fetch_addr == `PAVT_VEC_EXT)
        else $error("external vector not taken");
    AST_VEC_T0: assert property (@(posedge clk) disable iff (!rstn)
        (take_w && ready[1:0] == 2'b10) |=> fetch_addr == `PAVT_VEC_T0)
        else $error("timer 0 vector wrong");
    AST_VEC_T1: assert property (@(posedge clk) disable iff (!rstn)
        (take_w && ready[2:0] == 3'b100) |=> fetch_addr == `PAVT_VEC_T1)
        else $error("timer 1 vector wrong");
    AST_VEC_T2: assert property (@(posedge clk) disable iff (!rstn)
        (take_w && ready[3:0] == 4'b1000) |=> fetch_addr == `PAVT_VEC_T2)
        else $error("timer 2 vector wrong");
    AST_VEC_RC: assert property (@(posedge clk) disable iff (!rstn)
        (take_w && ready[4:0] == 5'b10000) |=> fetch_addr == `PAVT_VEC_RC)
        else $error("rc converter vector wrong");
    AST_VEC_ADPCM: assert property (@(posedge clk) disable iff (!rstn)
        (take_w && ready == 6'h20) |=> fetch_addr == `PAVT_VEC_ADPCM && pend[5] == $past(set_req[5]))
        else $error("adpcm vector wrong");
    AST_STACK_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        (stack_full && (|ready)) |=> !vector_take && (|pend))
        else $error("vector taken or request lost while stack full");
    AST_BANK_DEFER: assert property (@(posedge clk) disable iff (!rstn)
        (w_bank && !bank_upd) |=> active_bank == $past(active_bank))
        else $error("bank changed without a branch");
    AST_BANK_APPLY: assert property (@(posedge clk) disable iff (!rstn)
        branch_done |=> active_bank == $past(rom_bank_select[`PAVT_BANK_BITS-1:0]))
        else $error("bank not applied at branch");
    AST_TBL_TWO: assert property (@(posedge clk) disable iff (!rstn)
        tbl_go |=> (tbl_busy && !rom_sel_tbl) ##1 rom_sel_tbl ##1 (tbl_done && !tbl_busy))
        else $error("table read not two cycles");
    AST_TBL_LAST: assert property (@(posedge clk) disable iff (!rstn)
        (tbl_go && tbl_last_page) |-> ##2 rom_sel_tbl && rom_addr[12:8] == `PAVT_LAST_PAGE
        && rom_addr[17:13] == $past(rom_bank_select[`PAVT_BANK_BITS-1:0], 2))
        else $error("last page address wrong");
    AST_TBL_CUR: assert property (@(posedge clk) disable iff (!rstn)
        (tbl_go && !tbl_last_page) |-> ##2 rom_sel_tbl
        && rom_addr == {$past(table_pointer_high[1:0], 2), $past(table_pointer_middle, 2),
        $past(table_pointer_low, 2)})
        else $error("current table address wrong");
    AST_TBL_HB: assert property (@(posedge clk) disable iff (!rstn)
        !rom_sel_tbl |=> table_high_byte == $past(table_high_byte))
        else $error("table high byte changed outside a table read");
    AST_TBL_LOW: assert property (@(posedge clk) disable iff (!rstn)
        rom_sel_tbl |=> tbl_done && tbl_low_data == $past(rom_data[7:0])
        && table_high_byte == $past(rom_data[15:8]))
        else $error("table bytes not delivered");
endmodule
`default_nettype wire

// ---- hdl/pavt_cfg.svh ----
/*
 * constants of the program address, vector and table read block.
 * assumes a 20 MHz core clock and one clock per instruction cycle.
 */
`ifndef PAVT_CFG_SVH
`define PAVT_CFG_SVH
// variant: bank select bits, in-bank word address bits, full address bits
`define PAVT_BANK_BITS 5
`define PAVT_PAGE_BITS 13
`define PAVT_ADDR_BITS 18
`define PAVT_NUM_INT 6
// fixed vector words
`define PAVT_VEC_RESET 18'h00000
`define PAVT_VEC_EXT   18'h00004
`define PAVT_VEC_T0    18'h00008
`define PAVT_VEC_T1    18'h0000c
`define PAVT_VEC_T2    18'h00010
`define PAVT_VEC_RC    18'h00014
`define PAVT_VEC_ADPCM 18'h00018
// last page of a bank: address bits 12..8 all ones
`define PAVT_LAST_PAGE 5'h1f
// register indices, byte address is four times the index
`define PAVT_IDX_TBL_LOW  8'h07
`define PAVT_IDX_TBL_HB   8'h08
`define PAVT_IDX_BANK     8'h2d
`define PAVT_IDX_TBL_MID  8'h3c
`define PAVT_IDX_TBL_HIGH 8'h3d
`define PAVT_IDX_STATUS   8'h3e
// reset values
`define PAVT_RST_BANK 8'h00
`define PAVT_RST_TBL  8'h00
// status word fields
`define PAVT_ST_BANK 8
`define PAVT_ST_BUSY 16
// axi responses
`define PAVT_RESP_OKAY   2'b00
`define PAVT_RESP_SLVERR 2'b10
`endif

// ---- hdl/pavt_pkg.sv ----
/*
 * types of the program address, vector and table read block.
 * assumes pavt_cfg.svh is compiled alongside.
 */
`default_nettype none
package pavt_pkg;
    // table read sequence, gray coded along idle -> addr -> data
    typedef enum logic [1:0] {
        PAVT_TBL_IDLE = 2'b00,
        PAVT_TBL_ADDR = 2'b01,
        PAVT_TBL_DATA = 2'b11
    } pavt_tbl_state_t;
endpackage
`default_nettype wire

// ---- testbench/pavt_rom_model.sv ----
/* rom array model facing the block's program memory port.
   assumes the block reads rom_data in the same cycle that it drives rom_addr. */
`default_nettype none
module pavt_rom_model (
    input  wire logic [17:0] rom_addr, // word address from the block
    output logic      [15:0] rom_data  // sixteen bit word, no delay
);
    timeunit 1ns;
    timeprecision 1ns;
    // both bytes depend on the address, so a wrong bank or page bits 12..10 show
    assign rom_data = {rom_addr[7:0] ^ 8'ha5, rom_addr[17:10]};
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
/* self-checking bench of pavt_core: vectors, deferred bank, table reads, axi registers.
   assumes pavt_rom_model answers the rom port and one clock is one instruction cycle. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rstn = 1'b0, branch_done = 1'b0, stack_full = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tbl_start = 1'b0, tbl_last_page = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic [12:0] pc_next = 13'h1a5;
    logic [5:0]  irq = 6'h0;              // ext, t0, t1, t2, rc, adpcm requests
    logic [4:0]  int_enable = 5'h1f;
    logic [7:0]  tbl_dest = 8'h0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic rom_sel_tbl, vector_take, tbl_busy, tbl_done;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [15:0] rom_data;
    wire logic [17:0] rom_addr, fetch_addr;
    wire logic [7:0]  tbl_low_data, tbl_dest_out;
    int err_total = 0, comparisons = 0;
    logic [15:0] lf = 16'd19084;         // lfsr state, fixed seed
    pavt_rom_model rom_u (.rom_addr, .rom_data);
    pavt_core dut_u (.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pc_next, .branch_done, .ext_int_n(!irq[0]),
        .tmr0_ovf(irq[1]), .tmr1_ovf(irq[2]), .tmr2_ovf(irq[3]),
        .rc_converter_interrupt(irq[4]), .adpcm_int(irq[5]), .int_enable, .stack_full,
        .tbl_start, .tbl_last_page, .tbl_dest, .rom_data, .rom_addr, .rom_sel_tbl,
        .fetch_addr, .vector_take, .tbl_busy, .tbl_done, .tbl_low_data, .tbl_dest_out);
    always #25 clk = ~clk;               // 20 mhz
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    // case equality so an unknown never passes
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim();
        $display("err_total %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // write: both halves offered together, each dropped at its own ready
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'h0, s_axi_bresp);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic pulse(input logic [5:0] m);
        @(posedge clk);
        irq <= m;
        @(posedge clk);
        irq <= 6'h0;
    endtask
    // bounded wait for interrupt entry, then the vector word
    task automatic vec(input logic [17:0] e);
        int n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (vector_take !== 1'b1 && n < 20);
        chk("vector_take", 32'h1, vector_take);
        chk("vector", e, fetch_addr);
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  bk, lo, mi, hi, ds;
        logic [17:0] ta, ra;
        int n;
        repeat (20) @(posedge clk);
        chk("fetch_reset", 32'h0, fetch_addr);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        chk("fetch_first", 32'h1a5, fetch_addr);
        for (int i = 0; i < 6; i++) begin
            pulse(6'h1 << i);
            vec(18'h4 * (i + 1));
        end
        pulse(6'h06);
        vec(18'h8);
        vec(18'hc);
        // full stack, then a cleared enable, hold the request back until freed
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            stack_full <= (k == 0);
            int_enable[2] <= (k == 0);
            pulse(6'h04);
            n = 0;
            repeat (8) begin
                @(posedge clk);
                if (vector_take !== 1'b0) n++;
            end
            chk("withheld", 32'h0, n);
            stack_full <= 1'b0;
            int_enable[2] <= 1'b1;
            vec(18'hc);
        end
        d = rnd();
        bk = d[7:0];
        pc_next <= d[15:3];
        wr(12'hb4, bk);
        repeat (2) @(posedge clk);
        chk("bank_held", 32'h0, fetch_addr[17:13]);
        branch_done <= 1'b1;
        @(posedge clk);
        branch_done <= 1'b0;
        @(posedge clk);
        chk("fetch_bank", {bk[4:0], pc_next}, fetch_addr);
        rd(12'hf8, d, r);
        chk("status_bank", bk[4:0], d[12:8]);
        // both table modes at random pointers, timed in cycles
        for (int m = 0; m < 2; m++) begin
            d = rnd();
            lo = d[7:0];
            mi = d[15:8];
            d = rnd();
            hi = d[7:0];
            ds = d[15:8];
            wr(12'h1c, lo);
            wr(12'hf0, mi);
            wr(12'hf4, hi);
            ta = (m == 1) ? {bk[4:0], 5'h1f, lo} : {hi[1:0], mi, lo};
            @(posedge clk);
            tbl_start <= 1'b1;
            tbl_last_page <= (m == 1);
            tbl_dest <= ds;
            @(posedge clk);
            tbl_start <= 1'b0;
            n = 0;
            do begin
                @(posedge clk);
                n++;
                if (n == 1) chk("tbl_busy", 32'h1, tbl_busy);
                if (rom_sel_tbl === 1'b1) ra = rom_addr;
            end while (tbl_done !== 1'b1 && n < 9);
            chk("tbl_cycles", 32'h3, n);
            chk("tbl_addr", ta, ra);
            chk("tbl_low", ta[17:10], tbl_low_data);
            chk("tbl_dest", ds, tbl_dest_out);
            wr(12'h20, ~ta[7:0]);
            rd(12'h20, d, r);
            chk("tbl_high", ta[7:0] ^ 8'ha5, d[7:0]);
        end
        rd(12'hfc, d, r);
        chk("unmapped_resp", 32'h2, r);
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
